// [tsp_smbus_port.v]
/*
 * Two-wire slave port of a temperature monitor: start and stop detection,
 * address match, index pointer, register write hand-off, register read,
 * optional frame check byte, inactivity timeouts and the alarm output with
 * alert response.
 * Assumes the clock and data lines arrive as raw pin levels from another
 * domain, and that the register file beside it runs on sys_clk.
 */
`timescale 1ns/100ps
`include "tsp_regs.vh"

module tsp_smbus_port #(
    parameter TIMEOUT_CYCLES = `TSP_TIMEOUT_MS * `TSP_CLK_KHZ
) (
    sys_clk,
    rst,
    scl_in,
    serial_data_line_in,
    serial_data_line_out,
    serial_data_line_oe,
    alarm_out,
    alarm_oe,
    alarm_cause,
    status_flags_clear,
    reg_index,
    reg_rd_data,
    wr_valid,
    wr_ready,
    wr_index,
    wr_data,
    cfg_value
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire        scl_in;
    input  wire        serial_data_line_in;
    output wire        serial_data_line_out;
    output wire        serial_data_line_oe;
    output wire        alarm_out;
    output wire        alarm_oe;
    input  wire        alarm_cause;
    input  wire        status_flags_clear;
    output wire [7:0]  reg_index;
    input  wire [7:0]  reg_rd_data;
    output wire        wr_valid;
    input  wire        wr_ready;
    output wire [7:0]  wr_index;
    output wire [7:0]  wr_data;
    output wire [7:0]  cfg_value;

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK  = 3'h2;
    localparam [2:0] ST_WRX  = 3'h3;
    localparam [2:0] ST_TX   = 3'h4;
    localparam [2:0] ST_MACK = 3'h5;

    localparam [`TSP_TO_WIDTH-1:0] TO_LIMIT = TIMEOUT_CYCLES[`TSP_TO_WIDTH-1:0];

    // ------------------------------------------------------------------------
    // Pin synchronisers and line events
    // ------------------------------------------------------------------------
    reg  [2:0] scl_sync_reg;
    reg  [2:0] sda_sync_reg;
    wire       scl;
    wire       sda;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_ev;
    wire       stop_ev;

    always @(posedge sys_clk) begin
        if (rst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], serial_data_line_in};
        end
    end

    // Bit 0 is the first synchroniser stage and is only read by bit 1.
    assign scl      = scl_sync_reg[1];
    assign sda      = sda_sync_reg[1];
    assign scl_rise = scl & ~scl_sync_reg[2];
    assign scl_fall = ~scl & scl_sync_reg[2];
    assign start_ev = scl & scl_sync_reg[2] & ~sda & sda_sync_reg[2];
    assign stop_ev  = scl & scl_sync_reg[2] & sda & ~sda_sync_reg[2];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [2:0]                state_reg;
    reg  [2:0]                state_next;
    reg  [7:0]                shift_reg;
    reg  [2:0]                bit_cnt_reg;
    reg                       byte_done_reg;
    reg                       rw_reg;
    reg                       ara_reg;
    reg  [1:0]                wbyte_reg;
    reg                       pec_sent_reg;
    reg  [7:0]                ptr_reg;
    reg  [7:0]                cfg_reg;
    reg  [7:0]                crc_reg;
    reg  [7:0]                crc_keep_reg;
    reg                       sda_oe_reg;
    reg                       sda_out_reg;
    reg                       alarm_reg;
    reg                       alarm_out_reg;
    reg                       ara_done_reg;
    reg  [`TSP_TO_WIDTH-1:0]  idle_cnt_reg;
    reg                       push_reg;
    reg  [15:0]               push_data_reg;
    wire                      buf_in_ready;
    wire                      timeout;
    wire                      crc_fb;
    wire [7:0]                crc_step;
    wire [7:0]                tx_byte;
    wire                      addr_hit;
    wire                      ara_hit;

    // ------------------------------------------------------------------------
    // Inactivity timeout
    // ------------------------------------------------------------------------
    // The counter runs while a stuck-low line is watched; any edge clears it.
    // Both enables reset to zero, so no timeout can fire until software asks.
    wire watch_low = (~scl & cfg_reg[`TSP_CFG_CLK_TO_BIT])
                   | (~sda & cfg_reg[`TSP_CFG_DAT_TO_BIT]);
    wire line_edge = (scl ^ scl_sync_reg[2]) | (sda ^ sda_sync_reg[2]);

    always @(posedge sys_clk) begin
        if (rst) begin
            idle_cnt_reg <= {`TSP_TO_WIDTH{1'b0}};
        end else if (line_edge | ~watch_low | (state_reg == ST_IDLE)) begin
            idle_cnt_reg <= {`TSP_TO_WIDTH{1'b0}};
        end else if (idle_cnt_reg != TO_LIMIT) begin
            idle_cnt_reg <= idle_cnt_reg + {{(`TSP_TO_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign timeout = (idle_cnt_reg == TO_LIMIT);

    // ------------------------------------------------------------------------
    // Address decode and transmit byte
    // ------------------------------------------------------------------------
    assign addr_hit = (shift_reg[7:1] == `TSP_DEV_ADDR);
    assign ara_hit  = (shift_reg[7:1] == `TSP_ALERT_RESP_ADDR) & shift_reg[0] & alarm_reg;
    assign tx_byte  = pec_sent_reg ? crc_reg
                    : ara_reg ? {`TSP_DEV_ADDR, 1'b1}
                    : (ptr_reg == `TSP_CFG_INDEX) ? cfg_reg : reg_rd_data;
    assign crc_fb   = crc_reg[7] ^ sda;
    assign crc_step = {crc_reg[6:0], 1'b0} ^ (crc_fb ? `TSP_CRC_POLY : 8'h00);

    // ------------------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------------------
    // The port has no low-power gating of its own, so it keeps answering
    // while the rest of the device sits in standby.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                state_next = ST_IDLE;
            end
            ST_ADDR: begin
                if (scl_fall & byte_done_reg) begin
                    if (addr_hit | ara_hit) begin
                        state_next = ST_ACK;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_WRX: begin
                if (scl_fall & byte_done_reg) begin
                    if (wbyte_reg != `TSP_WBYTE_DATA || buf_in_ready) begin
                        state_next = ST_ACK;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    state_next = rw_reg ? ST_TX : ST_WRX;
                end
            end
            ST_TX: begin
                if (scl_rise & ~sda & ~sda_oe_reg) begin
                    state_next = ST_IDLE;
                end else if (scl_fall & byte_done_reg) begin
                    state_next = ST_MACK;
                end
            end
            ST_MACK: begin
                if (scl_rise) begin
                    // A further acknowledged byte after the data is the check byte.
                    state_next = (~sda & ~pec_sent_reg) ? ST_TX : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (start_ev) begin
            state_next = ST_ADDR;
        end else if (stop_ev | timeout) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Bit shifting, checksum and data line drive
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 3'h0;
            byte_done_reg <= 1'b0;
            rw_reg        <= 1'b0;
            ara_reg       <= 1'b0;
            wbyte_reg     <= `TSP_WBYTE_PTR;
            pec_sent_reg  <= 1'b0;
            crc_reg       <= `TSP_CRC_SEED;
            crc_keep_reg  <= `TSP_CRC_SEED;
            sda_oe_reg    <= 1'b0;
            sda_out_reg   <= 1'b0;
            ara_done_reg  <= 1'b0;
        end else begin
            ara_done_reg <= 1'b0;
            if (start_ev) begin
                // A repeated start goes back to the checksum of the last whole byte,
                // since the clock rise just before it was shifted but is no data.
                if (state_reg == ST_IDLE) begin
                    crc_reg      <= `TSP_CRC_SEED;
                    crc_keep_reg <= `TSP_CRC_SEED;
                end else begin
                    crc_reg <= crc_keep_reg;
                end
                bit_cnt_reg   <= 3'h0;
                byte_done_reg <= 1'b0;
                wbyte_reg     <= `TSP_WBYTE_PTR;
                pec_sent_reg  <= 1'b0;
                ara_reg       <= 1'b0;
                sda_oe_reg    <= 1'b0;
            end else if (state_next == ST_IDLE) begin
                sda_oe_reg    <= 1'b0;
                byte_done_reg <= 1'b0;
                bit_cnt_reg   <= 3'h0;
            end else if (scl_rise & (state_reg != ST_ACK) & (state_reg != ST_MACK)) begin
                shift_reg   <= {shift_reg[6:0], sda};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == `TSP_LAST_BIT) begin
                    byte_done_reg <= 1'b1;
                    crc_keep_reg  <= crc_step;
                end
                crc_reg <= crc_step;
            end else if (scl_fall) begin
                case (state_next)
                    ST_ACK: begin
                        byte_done_reg <= 1'b0;
                        sda_oe_reg    <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_reg  <= shift_reg[0];
                            ara_reg <= ~addr_hit;
                        end else if (wbyte_reg != `TSP_WBYTE_EXTRA) begin
                            wbyte_reg <= wbyte_reg + 2'h1;
                        end
                    end
                    ST_TX: begin
                        // Each bit is put out just after the clock falls.
                        if (state_reg == ST_TX) begin
                            sda_oe_reg <= ~shift_reg[7];
                        end else begin
                            shift_reg  <= tx_byte;
                            sda_oe_reg <= ~tx_byte[7];
                        end
                    end
                    ST_MACK: begin
                        sda_oe_reg    <= 1'b0;
                        byte_done_reg <= 1'b0;
                        ara_done_reg  <= ara_reg & ~pec_sent_reg;
                    end
                    default: begin
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
            if ((state_reg == ST_MACK) & (state_next == ST_TX)) begin
                // Loaded on the rise, as the first check bit goes out at the next fall.
                shift_reg    <= crc_reg;
                pec_sent_reg <= 1'b1;
                bit_cnt_reg  <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Index pointer, configuration and register write hand-off
    // ------------------------------------------------------------------------
    wire wr_byte_ack = (state_reg == ST_WRX) & (state_next == ST_ACK);

    always @(posedge sys_clk) begin
        if (rst) begin
            ptr_reg       <= 8'h00;
            cfg_reg       <= `TSP_CFG_RESET;
            push_reg      <= 1'b0;
            push_data_reg <= 16'h0000;
        end else begin
            if (push_reg & buf_in_ready) begin
                push_reg <= 1'b0;
            end
            if (wr_byte_ack & (wbyte_reg == `TSP_WBYTE_PTR)) begin
                ptr_reg <= shift_reg;
            end
            if (wr_byte_ack & (wbyte_reg == `TSP_WBYTE_DATA)) begin
                push_reg      <= 1'b1;
                push_data_reg <= {ptr_reg, shift_reg};
                if (ptr_reg == `TSP_CFG_INDEX) begin
                    cfg_reg <= shift_reg;
                end
            end
        end
    end

    // A full buffer refuses the data byte with a not-acknowledge rather than
    // dropping it, so the master sees the loss and can retry.
    tsp_pair_buf u_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (push_data_reg),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_index, wr_data})
    );

    // ------------------------------------------------------------------------
    // Alarm output
    // ------------------------------------------------------------------------
    // A new cause in the release cycle wins, so no alarm is lost.
    always @(posedge sys_clk) begin
        if (rst) begin
            alarm_reg     <= 1'b0;
            alarm_out_reg <= 1'b0;
        end else begin
            alarm_out_reg <= 1'b0;
            if (alarm_cause) begin
                alarm_reg <= 1'b1;
            end else if (ara_done_reg & status_flags_clear) begin
                alarm_reg <= 1'b0;
            end
        end
    end

    assign alarm_out            = alarm_out_reg;
    assign alarm_oe             = alarm_reg;
    assign serial_data_line_out = sda_out_reg;
    assign serial_data_line_oe  = sda_oe_reg;
    assign reg_index            = ptr_reg;
    assign cfg_value            = cfg_reg;

endmodule

// [tsp_regs.vh]
/*
 * Constants for the two-wire sensor slave port: bus addresses, configuration
 * register layout, timing figures and the frame check polynomial.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef TSP_REGS_VH
`define TSP_REGS_VH

// ----------------------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------------------
`define TSP_DEV_ADDR        7'h4C
`define TSP_ALERT_RESP_ADDR 7'h0C

// ----------------------------------------------------------------------------
// Configuration register (timeout enables) at index 0x22
// ----------------------------------------------------------------------------
`define TSP_CFG_INDEX       8'h22
`define TSP_CFG_RESET       8'h01
`define TSP_CFG_CLK_TO_BIT  7
`define TSP_CFG_DAT_TO_BIT  6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSP_TIMEOUT_MS      25
`define TSP_CLK_KHZ         40000
`define TSP_TO_WIDTH        21

// ----------------------------------------------------------------------------
// Frame check: x^8 + x^2 + x + 1, zero seed
// ----------------------------------------------------------------------------
`define TSP_CRC_POLY        8'h07
`define TSP_CRC_SEED        8'h00

// ----------------------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------------------
`define TSP_LAST_BIT        3'h7
`define TSP_WBYTE_PTR       2'h0
`define TSP_WBYTE_DATA      2'h1
`define TSP_WBYTE_EXTRA     2'h2
`define TSP_BUF_WIDTH       16

`endif

// [tsp_pair_buf.v]
/*
 * Two-entry buffer between the serial port and the register file, carrying
 * one register write (index and data) per entry.
 * Assumes one clock and a synchronous active-high reset shared with the port.
 */
`timescale 1ns/100ps
`include "tsp_regs.vh"

module tsp_pair_buf (
    sys_clk,
    rst,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input  wire                       sys_clk;
    input  wire                       rst;
    input  wire                       in_valid;
    output wire                       in_ready;
    input  wire [`TSP_BUF_WIDTH-1:0]  in_data;
    output wire                       out_valid;
    input  wire                       out_ready;
    output wire [`TSP_BUF_WIDTH-1:0]  out_data;

    reg  [`TSP_BUF_WIDTH-1:0] mem_reg [0:1];
    reg                       wr_ptr_reg;
    reg                       rd_ptr_reg;
    reg  [1:0]                count_reg;
    wire                      push;
    wire                      pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

    // Storage needs no reset; only the pointers and count say what is valid.
    always @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule

// [tsp_smbus_port_properties.sv]
/* Pin-level checker for the sensor slave port.
   Assumes it is bound onto tsp_smbus_port and sees only its ports. */
`timescale 1ns/100ps
module tsp_smbus_port_properties #(
    parameter TIMEOUT_CYCLES = 1000000
) (
    input wire       sys_clk,
    input wire       rst,
    input wire       scl_in,
    input wire       serial_data_line_out,
    input wire       serial_data_line_oe,
    input wire       alarm_out,
    input wire       alarm_oe,
    input wire       alarm_cause,
    input wire       status_flags_clear,
    input wire       wr_valid,
    input wire       wr_ready,
    input wire [7:0] wr_index,
    input wire [7:0] wr_data,
    input wire [7:0] cfg_value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    reg [31:0] hold_cnt_reg;
    reg        scl_q_reg;
    // Counts how long we pull data low while the clock sits low without edges.
    always @(posedge sys_clk) begin
        scl_q_reg <= scl_in;
        if (rst || !serial_data_line_oe || scl_in || scl_q_reg)
            hold_cnt_reg <= 32'h0;
        else
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
    end
    a_reset_cfg: assert property (
        $fell(rst) |-> cfg_value == 8'h01 && !serial_data_line_oe && !wr_valid)
        else $error("state after reset wrong");
    a_sda_drain: assert property (
        serial_data_line_oe |-> !serial_data_line_out) else $error("data pin driven high");
    a_alarm_drain: assert property (
        alarm_oe |-> !alarm_out) else $error("alarm pin driven high");
    a_alarm_set: assert property (
        alarm_cause |=> alarm_oe) else $error("alarm not raised");
    a_alarm_keep: assert property (
        alarm_oe && !status_flags_clear |=> alarm_oe) else $error("alarm dropped early");
    a_alarm_release: assert property (
        $fell(alarm_oe) |-> !$past(alarm_cause) && $past(status_flags_clear))
        else $error("alarm released while cause present");
    a_wr_hold: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_index) && $stable(wr_data))
        else $error("write word lost while stalled");
    a_timeout_free: assert property (
        cfg_value[7] |-> hold_cnt_reg <= TIMEOUT_CYCLES + 16)
        else $error("bus not released after timeout");
    c_alarm_free: cover property ($fell(alarm_oe));
    c_word_taken: cover property (wr_valid && wr_ready);
    c_ack_drive: cover property ($rose(serial_data_line_oe));
endmodule

// [tsp_host_model.sv]
/* Bus master model: start, stop and byte transfers on an open-drain data line.
   Assumes the bench resolves the wire with a pull-up from all drivers. */
`timescale 1ns/100ps
module tsp_host_model (
    output reg  scl,
    output reg  sda_low,
    input  wire sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task start_cond;
        begin
            if (!scl) begin
                #60 sda_low = 1'b0;
                #60 scl = 1'b1;
            end
            #60 sda_low = 1'b1;
            #60 scl = 1'b0;
        end
    endtask
    task stop_cond;
        begin
            #60 sda_low = 1'b1;
            #60 scl = 1'b1;
            #60 sda_low = 1'b0;
            #60;
        end
    endtask
    // Sampled late in the high phase: the slave answers a few cycles after the fall.
    task xfer(input [7:0] tx, input mack, output [7:0] rx, output ack);
        integer i;
        reg [8:0] bits;
        begin
            bits = {tx, !mack};
            for (i = 8; i >= 0; i = i - 1) begin
                #60 sda_low = !bits[i];
                #60 scl = 1'b1;
                #70 bits[i] = sda;
                #10 scl = 1'b0;
            end
            rx = bits[8:1];
            ack = !bits[0];
        end
    endtask
endmodule

// [tsp_smbus_port_tb.sv]
/* Self-checking bench: writes through the buffer, reads with frame check,
   refused addresses, alert response and bus timeouts.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/100ps
`include "tsp_regs.vh"
module tsp_smbus_port_tb;
    localparam TO = 200;
    reg        sys_clk, rst, alarm_cause, status_flags_clear, wr_ready, ak;
    reg  [7:0] reg_rd_data, rx, crc;
    reg  [7:0] idx [0:1];
    reg  [7:0] dat [0:1];
    wire       scl, m_low, sda, oe, alarm_oe, wr_valid;
    wire [7:0] reg_index, wr_index, wr_data, cfg_value;
    integer    failures, samples_checked, k, n;
    assign sda = !(m_low || oe);
    always #12.5 sys_clk = !sys_clk;
    tsp_host_model i_host (.scl(scl), .sda_low(m_low), .sda(sda));
    tsp_smbus_port #(.TIMEOUT_CYCLES(TO)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .scl_in(scl), .serial_data_line_in(sda), .serial_data_line_out(),
        .serial_data_line_oe(oe), .alarm_out(), .alarm_oe(alarm_oe),
        .alarm_cause(alarm_cause), .status_flags_clear(status_flags_clear),
        .reg_index(reg_index), .reg_rd_data(reg_rd_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data), .cfg_value(cfg_value));
    function [7:0] crc8(input [7:0] c, input [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
            crc8 = c;
        end
    endfunction
    task results;
        begin
            $display("checks %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("Error %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tx(input [7:0] b, input exp_ack);
        begin
            i_host.xfer(b, 1'b0, rx, ak);
            chk(ak, exp_ack);
            crc = crc8(crc, b);
        end
    endtask
    task rd(input [7:0] exp, input mack);
        begin
            i_host.xfer(8'hFF, mack, rx, ak);
            chk(rx, exp);
            crc = crc8(crc, rx);
        end
    endtask
    task wr(input [7:0] i, input [7:0] d, input ok);
        begin
            i_host.start_cond;
            tx(8'h98, 1'b1);
            tx(i, 1'b1);
            chk(reg_index, i);
            tx(d, ok);
            i_host.stop_cond;
        end
    endtask
    // The stream is only taken here, so earlier words pile up in the buffer.
    task pop(input [15:0] exp);
        begin
            for (n = 0; n < 200 && wr_valid !== 1'b1; n = n + 1)
                @(negedge sys_clk);
            if (n == 200) begin
                failures = failures + 1;
                results;
            end
            chk({wr_index, wr_data}, exp);
            wr_ready = 1'b1;
            @(negedge sys_clk);
            wr_ready = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    // A competing device sends comp at the same time; the line is the AND of both.
    task ara(input c, input clr, input [7:0] comp, input exp);
        begin
            @(negedge sys_clk);
            alarm_cause = c;
            status_flags_clear = clr;
            repeat (2) @(negedge sys_clk);
            i_host.start_cond;
            tx(8'h19, 1'b1);
            i_host.xfer(comp, 1'b0, rx, ak);
            chk(rx, comp & 8'h99);
            i_host.stop_cond;
            repeat (4) @(negedge sys_clk);
            chk(alarm_oe, exp);
        end
    endtask
    // Reads a zero byte but stalls the clock low after the first data bit is driven.
    task hold(input exp_oe, input [7:0] exp_rx);
        begin
            i_host.start_cond;
            tx(8'h98, 1'b1);
            tx(8'h10, 1'b1);
            i_host.start_cond;
            tx(8'h99, 1'b1);
            repeat (TO + 50) @(negedge sys_clk);
            chk(oe, exp_oe);
            rd(exp_rx, 1'b0);
            i_host.stop_cond;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        alarm_cause = 1'b0;
        status_flags_clear = 1'b1;
        wr_ready = 1'b0;
        reg_rd_data = 8'h00;
        crc = 8'h00;
        failures = 0;
        samples_checked = 0;
        k = $urandom(32'hEBEF);
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(cfg_value, `TSP_CFG_RESET);
        for (k = 0; k < 2; k = k + 1) begin
            idx[k] = $urandom & 8'h1F;
            dat[k] = $urandom;
            wr(idx[k], dat[k], 1'b1);
        end
        wr(8'h05, 8'h3C, 1'b0);
        for (k = 0; k < 2; k = k + 1)
            pop({idx[k], dat[k]});
        @(negedge sys_clk);
        reg_rd_data = $urandom;
        crc = 8'h00;
        i_host.start_cond;
        tx(8'h98, 1'b1);
        tx(8'h10, 1'b1);
        i_host.start_cond;
        tx(8'h99, 1'b1);
        rd(reg_rd_data, 1'b1);
        rd(crc, 1'b0);
        i_host.stop_cond;
        i_host.start_cond;
        tx(8'h9A, 1'b0);
        i_host.stop_cond;
        i_host.start_cond;
        tx(8'h19, 1'b0);
        i_host.stop_cond;
        ara(1'b1, 1'b1, 8'hFF, 1'b1);
        ara(1'b0, 1'b0, 8'hFF, 1'b1);
        ara(1'b0, 1'b1, 8'h91, 1'b1);
        ara(1'b0, 1'b1, 8'hFF, 1'b0);
        reg_rd_data = 8'h00;
        hold(1'b1, 8'h00);
        wr(8'h22, 8'hC1, 1'b1);
        pop(16'h22C1);
        chk(cfg_value, 8'hC1);
        hold(1'b0, 8'hFF);
        results;
    end
endmodule
bind tsp_smbus_port tsp_smbus_port_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .alarm_cause(alarm_cause),
    .status_flags_clear(status_flags_clear), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_index(wr_index), .wr_data(wr_data), .cfg_value(cfg_value));
